// File: src/fdc_compat_pkg.sv
// Package with status byte layout, strap modes and phase codes for the status and compat block
`default_nettype none
package fdc_compat_pkg;

    // Transfer status byte two bit positions
    localparam int unsigned ST2_CONTROL_MARK_BIT = 6;
    localparam int unsigned ST2_CRC_ERROR_BIT    = 5;
    localparam int unsigned ST2_WRONG_CYL_BIT    = 4;
    localparam int unsigned ST2_BAD_CYL_BIT      = 1;
    localparam int unsigned ST2_MISSING_MARK_BIT = 0;

    // Drive state status byte three bit positions
    localparam int unsigned ST3_ZERO_BIT         = 7;
    localparam int unsigned ST3_WRITE_PROT_BIT   = 6;
    localparam int unsigned ST3_ONE_HI_BIT       = 5;
    localparam int unsigned ST3_TRACK_ZERO_BIT   = 4;
    localparam int unsigned ST3_ONE_LO_BIT       = 3;
    localparam int unsigned ST3_HEAD_SIDE_BIT    = 2;
    localparam int unsigned ST3_DRIVE_SEL_HI_BIT = 1;
    localparam int unsigned ST3_DRIVE_SEL_LO_BIT = 0;

    // Values after reset
    localparam logic [7:0] STATUS_TWO_RESET  = 8'h00;
    localparam logic [7:0] RESULT_BYTE_RESET = 8'h00;

    // Track number that marks a hard-error track
    localparam logic [7:0] BAD_TRACK_NUMBER = 8'hFF;

    // Result byte selector
    localparam logic RESULT_SEL_TWO   = 1'b0;
    localparam logic RESULT_SEL_THREE = 1'b1;

    // Controller phase codes
    localparam logic [1:0] PHASE_COMMAND = 2'h0;
    localparam logic [1:0] PHASE_EXECUTE = 2'h1;
    localparam logic [1:0] PHASE_RESULT  = 2'h2;
    localparam logic [1:0] PHASE_IDLE    = 2'h3;

    // Compatibility modes selected by the straps
    typedef enum logic [2:0] {
        MODE_LOW_FIRST  = 3'b001,
        MODE_HIGH       = 3'b010,
        MODE_LOW_SECOND = 3'b100
    } compat_mode_t;

    localparam compat_mode_t MODE_RESET = MODE_HIGH;

endpackage : fdc_compat_pkg
`default_nettype wire

// File: src/fdc_status_compat.sv
// Status byte result path and strap-selected compatibility logic
// Behaviour
// - Status byte two bits 7, 3 and 2 always read zero.
// - Control mark set on data mark type opposite to command's.
// - Data field CRC failure sets status two bit 5.
// - ID track differing from internal track sets wrong cylinder.
// - Differing ID track equal to FF also sets bad cylinder.
// - No data or deleted data mark found sets bit 0.
// - Status three bit 7 reads zero, bits 5 and 3 read one.
// - Status three bit 6 shows write protect input level.
// - Status three bit 4 shows track zero input level.
// - Status three bit 2 shows head side output level.
// - Status three bits 1 and 0 show drive select outputs.
// - Straps sampled at hardware reset choose one of three modes.
// - Platform strap low: density select active low for high rates.
// - Platform strap high: density select active high for high rates.
// - First low mode always drives DMA request and interrupt.
// - First low mode: terminal count active low, qualified by acknowledge.
// - High mode tristates request and interrupt while gate bit is 0.
// - High mode: terminal count active high, qualified by acknowledge low.
// - Second low mode gates and takes terminal count like high mode.
// - FIFO stays in byte mode after reset until setup enables it.
// - Enabled FIFO bursts only in execution phase, byte mode otherwise.
// - Status bytes appear only as result bytes, never at a port.
`default_nettype none
module fdc_status_compat
    import fdc_compat_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       nrst_i,
    // Straps
    input  wire logic       platform_strap_i,
    input  wire logic       encoding_strap_i,
    // Drive cable levels
    input  wire logic       write_protect_pin_i,
    input  wire logic       track_zero_pin_i,
    input  wire logic       head_side_pin_i,
    input  wire logic [1:0] drive_select_pins_i,
    // Sector events from the read engine
    input  wire logic       status_clear_i,
    input  wire logic       id_check_i,
    input  wire logic [7:0] id_track_i,
    input  wire logic [7:0] internal_track_i,
    input  wire logic       mark_seen_i,
    input  wire logic       mark_deleted_i,
    input  wire logic       deleted_cmd_i,
    input  wire logic       crc_fail_i,
    input  wire logic       mark_missing_i,
    // Result byte path
    input  wire logic       result_rd_i,
    input  wire logic       result_sel_i,
    output logic      [7:0] result_byte_o,
    output logic            result_valid_o,
    // Density select
    input  wire logic       high_rate_i,
    input  wire logic       polarity_invert_i,
    output logic            density_select_o,
    // DMA and interrupt pins
    input  wire logic       dma_output_gate_i,
    input  wire logic       dma_request_core_i,
    input  wire logic       int_core_i,
    output logic            dma_request_o,
    output logic            dma_request_oe_n_o,
    output logic            int_o,
    output logic            int_oe_n_o,
    input  wire logic       terminal_count_i,
    input  wire logic       dma_acknowledge_n_i,
    output logic            tc_accepted_o,
    // FIFO mode
    input  wire logic       setup_strobe_i,
    input  wire logic       setup_fifo_enable_i,
    input  wire logic [1:0] phase_i,
    output logic            fifo_enabled_o,
    output logic            burst_mode_o,
    output compat_mode_t    compat_mode_o
);

    compat_mode_t mode;
    logic         strap_taken;
    logic         fifo_enabled;
    logic         drive_pins;
    logic         tc_level;
    logic [7:0]   status_two;
    logic [7:0]   status_three;

    // True for modes whose DMA pins and terminal count behave like high mode
    function automatic logic high_style(input compat_mode_t m);
        high_style = (m == MODE_HIGH) || (m == MODE_LOW_SECOND);
    endfunction

    // Platform strap level implied by the mode
    function automatic logic strap_low(input compat_mode_t m);
        strap_low = (m == MODE_LOW_FIRST) || (m == MODE_LOW_SECOND);
    endfunction

    xfer_status_flags u_flags (
        .core_clk_i       (core_clk_i),
        .nrst_i           (nrst_i),
        .clear_i          (status_clear_i),
        .id_check_i       (id_check_i),
        .id_track_i       (id_track_i),
        .internal_track_i (internal_track_i),
        .mark_seen_i      (mark_seen_i),
        .mark_deleted_i   (mark_deleted_i),
        .deleted_cmd_i    (deleted_cmd_i),
        .crc_fail_i       (crc_fail_i),
        .mark_missing_i   (mark_missing_i),
        .status_two_o     (status_two)
    );

    // Straps are caught on the first clock after reset release, then frozen
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            mode        <= MODE_RESET;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            case ({platform_strap_i, encoding_strap_i})
                2'b00:   mode <= MODE_LOW_SECOND;
                2'b01:   mode <= MODE_LOW_FIRST;
                default: mode <= MODE_HIGH;
            endcase
        end
    end

    assign compat_mode_o = mode;

    always_comb begin
        status_three                       = 8'h00;
        status_three[ST3_ZERO_BIT]         = 1'b0;
        status_three[ST3_ONE_HI_BIT]       = 1'b1;
        status_three[ST3_ONE_LO_BIT]       = 1'b1;
        status_three[ST3_WRITE_PROT_BIT]   = write_protect_pin_i;
        status_three[ST3_TRACK_ZERO_BIT]   = track_zero_pin_i;
        status_three[ST3_HEAD_SIDE_BIT]    = head_side_pin_i;
        status_three[ST3_DRIVE_SEL_HI_BIT] = drive_select_pins_i[1];
        status_three[ST3_DRIVE_SEL_LO_BIT] = drive_select_pins_i[0];
    end

    // The status bytes leave only through this result read
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            result_byte_o  <= RESULT_BYTE_RESET;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= result_rd_i;
            if (result_rd_i) begin
                result_byte_o <= (result_sel_i == RESULT_SEL_THREE) ? status_three
                                                                    : status_two;
            end
        end
    end

    // Density polarity follows the platform strap, flipped by the invert pin
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            density_select_o <= 1'b0;
        end else if (strap_low(mode)) begin
            density_select_o <= ~high_rate_i ^ polarity_invert_i;
        end else begin
            density_select_o <= high_rate_i ^ polarity_invert_i;
        end
    end

    assign drive_pins         = !high_style(mode) || dma_output_gate_i;
    assign dma_request_oe_n_o = ~drive_pins;
    assign int_oe_n_o         = ~drive_pins;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            dma_request_o <= 1'b0;
            int_o         <= 1'b0;
        end else begin
            dma_request_o <= dma_request_core_i;
            int_o         <= int_core_i;
        end
    end

    assign tc_level = high_style(mode) ? terminal_count_i : ~terminal_count_i;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            tc_accepted_o <= 1'b0;
        end else begin
            tc_accepted_o <= tc_level && !dma_acknowledge_n_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            fifo_enabled <= 1'b0;
        end else if (setup_strobe_i) begin
            fifo_enabled <= setup_fifo_enable_i;
        end
    end

    assign fifo_enabled_o = fifo_enabled;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            burst_mode_o <= 1'b0;
        end else begin
            burst_mode_o <= fifo_enabled && (phase_i == PHASE_EXECUTE);
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    st2_zero_bits_a: assert property (
        result_rd_i && result_sel_i == RESULT_SEL_TWO |=>
            result_valid_o && result_byte_o[7] == 1'b0 && result_byte_o[3:2] == 2'b00)
        else $error("status two unused bits not zero");

    st2_wrong_cyl_a: assert property (
        id_check_i && id_track_i != internal_track_i ##1
            result_rd_i && result_sel_i == RESULT_SEL_TWO |=> result_byte_o[ST2_WRONG_CYL_BIT])
        else $error("wrong cylinder not reported");

    st2_ctrl_mark_a: assert property (
        mark_seen_i && mark_deleted_i != deleted_cmd_i ##1
            result_rd_i && result_sel_i == RESULT_SEL_TWO |=> result_byte_o[ST2_CONTROL_MARK_BIT])
        else $error("control mark not reported");

    st3_layout_a: assert property (
        result_rd_i && result_sel_i == RESULT_SEL_THREE |=>
            result_byte_o[7] == 1'b0 && result_byte_o[5] && result_byte_o[3])
        else $error("status three fixed bits wrong");

    st3_pins_a: assert property (
        result_rd_i && result_sel_i == RESULT_SEL_THREE |=>
            result_byte_o[ST3_WRITE_PROT_BIT] == $past(write_protect_pin_i) &&
            result_byte_o[ST3_TRACK_ZERO_BIT] == $past(track_zero_pin_i) &&
            result_byte_o[ST3_HEAD_SIDE_BIT] == $past(head_side_pin_i) &&
            result_byte_o[1:0] == $past(drive_select_pins_i))
        else $error("status three pin levels wrong");

    mode_held_a: assert property (strap_taken |=> $stable(mode))
        else $error("compat mode changed after latch");

    pin_gate_a: assert property (
        high_style(mode) && !dma_output_gate_i |-> dma_request_oe_n_o && int_oe_n_o)
        else $error("pins driven while gated off");

    always_drive_a: assert property (
        mode == MODE_LOW_FIRST |-> !dma_request_oe_n_o && !int_oe_n_o)
        else $error("first low mode let pins float");

    tc_qualify_a: assert property (dma_acknowledge_n_i |=> !tc_accepted_o)
        else $error("terminal count taken without acknowledge");

    tc_low_mode_a: assert property (
        mode == MODE_LOW_FIRST && !terminal_count_i && !dma_acknowledge_n_i |=> tc_accepted_o)
        else $error("active low terminal count missed");

    density_pol_a: assert property (
        !strap_low(mode) && high_rate_i && !polarity_invert_i && $stable(mode) |=>
            density_select_o)
        else $error("density select polarity wrong in high mode");

    burst_phase_a: assert property (
        phase_i != PHASE_EXECUTE || !fifo_enabled |=> !burst_mode_o)
        else $error("burst outside execution phase");

    cover_read_three_c: cover property (result_rd_i && result_sel_i == RESULT_SEL_THREE);
    cover_bad_cyl_c:    cover property (id_check_i && id_track_i == BAD_TRACK_NUMBER &&
                                        internal_track_i != BAD_TRACK_NUMBER);
    cover_burst_c:      cover property (burst_mode_o);
    cover_gated_c:      cover property (dma_request_oe_n_o);

endmodule // fdc_status_compat
`default_nettype wire

// File: src/xfer_status_flags.sv
// Sticky flags of the transfer status byte two
`default_nettype none
module xfer_status_flags
    import fdc_compat_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       clear_i,
    input  wire logic       id_check_i,
    input  wire logic [7:0] id_track_i,
    input  wire logic [7:0] internal_track_i,
    input  wire logic       mark_seen_i,
    input  wire logic       mark_deleted_i,
    input  wire logic       deleted_cmd_i,
    input  wire logic       crc_fail_i,
    input  wire logic       mark_missing_i,
    output logic      [7:0] status_two_o
);

    logic control_mark_flag;
    logic data_field_crc_error;
    logic wrong_cylinder_flag;
    logic bad_cylinder_flag;
    logic missing_data_mark_flag;
    logic track_differs;
    logic mark_mismatch;

    assign track_differs = id_check_i && (id_track_i != internal_track_i);
    assign mark_mismatch = mark_seen_i && (mark_deleted_i != deleted_cmd_i);

    // Each flag: a set in the same cycle as the clear wins
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            control_mark_flag <= 1'b0;
        end else if (mark_mismatch) begin
            control_mark_flag <= 1'b1;
        end else if (clear_i) begin
            control_mark_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            data_field_crc_error <= 1'b0;
        end else if (crc_fail_i) begin
            data_field_crc_error <= 1'b1;
        end else if (clear_i) begin
            data_field_crc_error <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            wrong_cylinder_flag <= 1'b0;
            bad_cylinder_flag   <= 1'b0;
        end else begin
            if (track_differs) begin
                wrong_cylinder_flag <= 1'b1;
            end else if (clear_i) begin
                wrong_cylinder_flag <= 1'b0;
            end
            if (track_differs && (id_track_i == BAD_TRACK_NUMBER)) begin
                bad_cylinder_flag <= 1'b1;
            end else if (clear_i) begin
                bad_cylinder_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            missing_data_mark_flag <= 1'b0;
        end else if (mark_missing_i) begin
            missing_data_mark_flag <= 1'b1;
        end else if (clear_i) begin
            missing_data_mark_flag <= 1'b0;
        end
    end

    always_comb begin
        status_two_o                       = STATUS_TWO_RESET;
        status_two_o[ST2_CONTROL_MARK_BIT] = control_mark_flag;
        status_two_o[ST2_CRC_ERROR_BIT]    = data_field_crc_error;
        status_two_o[ST2_WRONG_CYL_BIT]    = wrong_cylinder_flag;
        status_two_o[ST2_BAD_CYL_BIT]      = bad_cylinder_flag;
        status_two_o[ST2_MISSING_MARK_BIT] = missing_data_mark_flag;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    bad_implies_wrong_a: assert property ($rose(bad_cylinder_flag) |-> wrong_cylinder_flag)
        else $error("bad cylinder set without wrong cylinder");
    set_beats_clear_a: assert property (clear_i && crc_fail_i |=> data_field_crc_error)
        else $error("crc error lost against clear");

endmodule // xfer_status_flags
`default_nettype wire

// File: verification/host_dma_model.sv
// Host and DMA controller side model: terminal count, acknowledge and the shared request pin
`default_nettype none
module host_dma_model (
    input  wire logic core_clk_i,
    input  wire logic term_cmd_i,
    input  wire logic ack_cmd_i,
    input  wire logic dma_request_i,
    input  wire logic dma_request_oe_n_i,
    output logic      terminal_count_o,
    output logic      dma_acknowledge_n_o,
    output logic      dma_request_wire_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic last_level = 1'b0;

    // Acknowledge is driven active low by the DMA controller
    assign terminal_count_o    = term_cmd_i;
    assign dma_acknowledge_n_o = ~ack_cmd_i;

    always @(posedge core_clk_i) begin
        if (!dma_request_oe_n_i) begin
            last_level <= dma_request_i;
        end
    end

    // A released pin floats; show the inverse of its last driven level
    assign dma_request_wire_o = dma_request_oe_n_i ? ~last_level : dma_request_i;
endmodule // host_dma_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the status byte and compatibility block
`default_nettype none
module testbench;
    import fdc_compat_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'h0, nrst = 1'h0, plat = 1'h0, enc = 1'h0, wp = 1'h0, tz = 1'h0, hs = 1'h0;
    logic [1:0] dsel = 2'h0, phase = 2'h0;
    logic [7:0] id_trk = 8'h00, int_trk = 8'h00, res_byte;
    logic clr = 1'h0, idc = 1'h0, seen = 1'h0, del_mark = 1'h0, del_cmd = 1'h0;
    logic crc = 1'h0, miss = 1'h0;
    logic rd_req = 1'h0, rd_sel = 1'h0, res_valid, hi_rate = 1'h0, pol = 1'h0, dens;
    logic gate = 1'h0, req_core = 1'h0, irq_core = 1'h0, req_q, req_oe_n, irq_q, irq_oe_n;
    logic term_cmd = 1'h0, ack_cmd = 1'h0, term_lvl, ack_n, accepted, req_wire;
    logic setup = 1'h0, setup_en = 1'h0, fifo_en, burst;
    logic [2:0] em;
    compat_mode_t mode;
    int n_fail = 0, cmp_count = 0, cycles = 0;

    always #50 clk = ~clk;

    fdc_status_compat i_dut (
        .core_clk_i(clk), .nrst_i(nrst), .platform_strap_i(plat), .encoding_strap_i(enc),
        .write_protect_pin_i(wp), .track_zero_pin_i(tz), .head_side_pin_i(hs),
        .drive_select_pins_i(dsel), .status_clear_i(clr), .id_check_i(idc),
        .id_track_i(id_trk), .internal_track_i(int_trk), .mark_seen_i(seen),
        .mark_deleted_i(del_mark), .deleted_cmd_i(del_cmd), .crc_fail_i(crc),
        .mark_missing_i(miss), .result_rd_i(rd_req), .result_sel_i(rd_sel),
        .result_byte_o(res_byte), .result_valid_o(res_valid), .high_rate_i(hi_rate),
        .polarity_invert_i(pol), .density_select_o(dens), .dma_output_gate_i(gate),
        .dma_request_core_i(req_core), .int_core_i(irq_core), .dma_request_o(req_q),
        .dma_request_oe_n_o(req_oe_n), .int_o(irq_q), .int_oe_n_o(irq_oe_n),
        .terminal_count_i(term_lvl), .dma_acknowledge_n_i(ack_n), .tc_accepted_o(accepted),
        .setup_strobe_i(setup), .setup_fifo_enable_i(setup_en), .phase_i(phase),
        .fifo_enabled_o(fifo_en), .burst_mode_o(burst), .compat_mode_o(mode));

    host_dma_model i_host (
        .core_clk_i(clk), .term_cmd_i(term_cmd), .ack_cmd_i(ack_cmd),
        .dma_request_i(req_q), .dma_request_oe_n_i(req_oe_n),
        .terminal_count_o(term_lvl), .dma_acknowledge_n_o(ack_n),
        .dma_request_wire_o(req_wire));

    task automatic conclude();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen_v, input logic [7:0] exp_v);
        cmp_count++;
        if (seen_v !== exp_v) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp_v, seen_v);
        end
    endtask

    task automatic wait2();
        repeat (2) @(negedge clk);
    endtask

    task automatic do_reset();
        nrst = 0;
        repeat (20) @(negedge clk);
        nrst = 1;
        repeat (3) @(negedge clk);
    endtask

    // Result byte read: request held over one rising edge, answer in the next cycle
    task automatic rd(input logic s, input logic [7:0] e);
        rd_sel = s;
        rd_req = 1;
        @(negedge clk);
        rd_req = 0;
        chk("result_valid", {7'h00, res_valid}, 8'h01);
        chk("result_byte", res_byte, e);
        @(negedge clk);
        chk("result_valid_end", {7'h00, res_valid}, 8'h00);
    endtask

    // One-cycle sector events: {missing, crc, mark seen, id check, clear}
    task automatic ev(input logic [4:0] v);
        {miss, crc, seen, idc, clr} = v;
        @(negedge clk);
        {miss, crc, seen, idc, clr} = 5'h00;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        for (int m = 0; m < 3; m++) begin
            plat = (m == 2);
            enc = (m == 0);
            do_reset();
            em = plat ? 3'b010 : (enc ? 3'b001 : 3'b100);
            chk("mode", {5'h00, mode}, {5'h00, em});
            plat = ~plat;
            enc = ~enc;
            wait2();
            chk("mode_held", {5'h00, mode}, {5'h00, em});
            for (int k = 0; k < 4; k++) begin
                hi_rate = k[0];
                pol = k[1];
                wait2();
                chk("density", {7'h00, dens}, {7'h00, ((m != 2) ? ~k[0] : k[0]) ^ k[1]});
            end
            for (int k = 0; k < 4; k++) begin
                gate = k[0];
                req_core = k[1];
                irq_core = k[1];
                wait2();
                chk("req_oe_n", {7'h00, req_oe_n}, {7'h00, (m == 0) ? 1'b0 : ~k[0]});
                chk("int_oe_n", {7'h00, irq_oe_n}, {7'h00, (m == 0) ? 1'b0 : ~k[0]});
                if (m == 0 || k[0]) begin
                    chk("req_wire", {7'h00, req_wire}, {7'h00, k[1]});
                    chk("int_pin", {7'h00, irq_q}, {7'h00, k[1]});
                end
            end
            for (int k = 0; k < 4; k++) begin
                term_cmd = k[0];
                ack_cmd = k[1];
                wait2();
                chk("tc_accept", {7'h00, accepted},
                    {7'h00, ((m == 0) ? ~k[0] : k[0]) & k[1]});
            end
            phase = 2'h1;
            wait2();
            chk("fifo_reset", {6'h00, fifo_en, burst}, 8'h00);
            setup_en = 1;
            setup = 1;
            @(negedge clk);
            setup = 0;
            chk("fifo_on", {7'h00, fifo_en}, 8'h01);
            for (int p = 0; p < 4; p++) begin
                phase = p[1:0];
                wait2();
                chk("burst", {7'h00, burst}, {7'h00, p == 1});
            end
        end
        // Timing-sensitive host: FIFO off, then one status query per logical drive
        setup_en = 0;
        setup = 1;
        @(negedge clk);
        setup = 0;
        phase = 2'h1;
        wait2();
        chk("fifo_off", {6'h00, fifo_en, burst}, 8'h00);
        for (int d = 0; d < 4; d++) begin
            dsel = d[1:0];
            rd(RESULT_SEL_THREE, {1'b0, wp, 1'b1, tz, 1'b1, hs, dsel});
        end
        ev(5'h01);
        rd(RESULT_SEL_TWO, 8'h00);
        id_trk = 8'h05;
        int_trk = 8'h05;
        ev(5'h02);
        rd(RESULT_SEL_TWO, 8'h00);
        id_trk = 8'hFF;
        int_trk = 8'h03;
        ev(5'h02);
        rd(RESULT_SEL_TWO, 8'h12);
        ev(5'h01);
        id_trk = 8'h07;
        ev(5'h02);
        rd(RESULT_SEL_TWO, 8'h10);
        ev(5'h01);
        id_trk = 8'hFF;
        int_trk = 8'hFF;
        ev(5'h02);
        rd(RESULT_SEL_TWO, 8'h00);
        for (int k = 0; k < 4; k++) begin
            del_mark = k[0];
            del_cmd = k[1];
            ev(5'h04);
            rd(RESULT_SEL_TWO, (k[0] != k[1]) ? 8'h40 : 8'h00);
            ev(5'h01);
        end
        ev(5'h08);
        rd(RESULT_SEL_TWO, 8'h20);
        ev(5'h01);
        ev(5'h10);
        rd(RESULT_SEL_TWO, 8'h01);
        del_mark = 1;
        del_cmd = 0;
        int_trk = 8'h00;
        ev(5'h1F);
        rd(RESULT_SEL_TWO, 8'h73);
        rd(RESULT_SEL_TWO, 8'h73);
        for (int i = 0; i < 32; i++) begin
            {dsel, hs, tz, wp} = i[4:0];
            rd(RESULT_SEL_THREE, {1'b0, wp, 1'b1, tz, 1'b1, hs, dsel});
        end
        conclude();
    end
endmodule // testbench
`default_nettype wire
